// file: design/npa_pkg.sv
// Behaviour
// - Partner next-page word sits at management address 0x08, 16 bits, read-only, resets zero.
// - Bit 15 mirrors received more-pages flag; zero means final page of exchange.
// - Bit 15 at one means further pages follow the current message.
// - Bit 15 takes its value directly from the received link control word.
// - Reserved bit 14 always reads zero, whatever was written.
// - Bit 13 gives page format: zero unformatted, one message page.
// - Bit 12 gives second acknowledge: zero cannot comply, one can comply.
// - Each successive next-page word carries the inverse toggle of the previous one.
// - First next-page word toggle equals inverse of base word bit 11.
// - Bits 10 to 0 hold the 11-bit message or unformatted code field.
// - Page-received flag latches high whenever a new word is stored.
package npa_pkg;

  // Register map and field layout.
  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  ADDR_NEXT_PAGE  = 5'h08;
  localparam int          BIT_MORE_PAGES  = 15;
  localparam int          BIT_RESERVED    = 14;
  localparam int          BIT_PAGE_FORMAT = 13;
  localparam int          BIT_SECOND_ACK  = 12;
  localparam int          BIT_TOGGLE      = 11;
  localparam int          CODE_MSB        = 10;
  localparam int          CODE_LSB        = 0;
  localparam logic [15:0] RESET_NEXT_PAGE = 16'h0000;
  localparam int          BASE_TOGGLE_BIT = 11;

  // Serial management frame layout.
  localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [4:0]  OP_BITS_LAST    = 5'h01;
  localparam logic [4:0]  ADDR_BITS_LAST  = 5'h04;
  localparam logic [4:0]  TA_BITS_LAST    = 5'h01;
  localparam logic [4:0]  DATA_BITS_LAST  = 5'h0f;

endpackage

// file: design/npa_word_capture.sv
`timescale 1ns/1ps
module npa_word_capture
  import npa_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              pageWordValid,
  input  wire logic [15:0]       pageWord,
  input  wire logic [15:0]       baseWord,
  input  wire logic              exchangeStart,
  input  wire logic              pageReceivedClear,
  output logic      [15:0]       storedWord,
  output logic                   pageReceived,
  output logic                   toggleError
);

  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic        received_reg;
  logic        received_next;
  logic        expect_reg;
  logic        expect_next;
  logic        error_reg;
  logic        error_next;

  // Next values of the stored word, the latching flag and the toggle tracker.
  always_comb begin
    word_next     = word_reg;
    received_next = received_reg;
    expect_next   = expect_reg;
    error_next    = error_reg;
    if (pageReceivedClear) begin
      received_next = 1'b0;
    end
    if (exchangeStart) begin
      expect_next = ~baseWord[BASE_TOGGLE_BIT];
      error_next  = 1'b0;
    end
    if (pageWordValid) begin
      // The whole word is replaced in one edge; no field is ever updated alone.
      word_next                           = pageWord;
      word_next[BIT_MORE_PAGES]           = pageWord[BIT_MORE_PAGES];
      word_next[BIT_RESERVED]             = 1'b0;
      word_next[BIT_PAGE_FORMAT]          = pageWord[BIT_PAGE_FORMAT];
      word_next[BIT_SECOND_ACK]           = pageWord[BIT_SECOND_ACK];
      word_next[CODE_MSB:CODE_LSB]        = pageWord[CODE_MSB:CODE_LSB];
      // A new page beats a clear in the same cycle, so no page goes unseen.
      received_next = 1'b1;
      expect_next   = ~pageWord[BIT_TOGGLE];
      if (pageWord[BIT_TOGGLE] != expect_reg) begin
        error_next = 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      word_reg     <= RESET_NEXT_PAGE;
      received_reg <= 1'b0;
      expect_reg   <= 1'b0;
      error_reg    <= 1'b0;
    end else begin
      word_reg     <= word_next;
      received_reg <= received_next;
      expect_reg   <= expect_next;
      error_reg    <= error_next;
    end
  end

  assign storedWord   = word_reg;
  assign pageReceived = received_reg;
  assign toggleError  = error_reg;

endmodule

// file: design/next_page_partner_ability_reg.sv
`timescale 1ns/1ps
module next_page_partner_ability_reg
  import npa_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              mdc,
  input  wire logic              mdioIn,
  output logic                   mdioOut,
  output logic                   mdioOe,
  input  wire logic [4:0]        phyAddr,
  input  wire logic              pageWordValid,
  input  wire logic [15:0]       pageWord,
  input  wire logic [15:0]       baseWord,
  input  wire logic              exchangeStart,
  input  wire logic              pageReceivedClear,
  output logic      [15:0]       partnerWord,
  output logic                   pageReceived,
  output logic                   toggleError
);

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_OPCODE,
    ST_PHY,
    ST_REG,
    ST_TURN,
    ST_DATA
  } frame_e;

  // Pin synchronisers. The first stage of each feeds only the second.
  logic        mdcMeta_reg;
  logic        mdcSync_reg;
  logic        mdcLast_reg;
  logic        mdioMeta_reg;
  logic        mdioSync_reg;

  // Frame decoder state.
  frame_e      state_reg;
  frame_e      state_next;
  logic [5:0]  preCnt_reg;
  logic [5:0]  preCnt_next;
  logic [4:0]  bitCnt_reg;
  logic [4:0]  bitCnt_next;
  logic [4:0]  field_reg;
  logic [4:0]  field_next;
  logic        isRead_reg;
  logic        isRead_next;
  logic        match_reg;
  logic        match_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic        out_reg;
  logic        out_next;
  logic        oe_reg;
  logic        oe_next;

  logic        mdcRise;
  logic        bitIn;
  logic [4:0]  fieldIn;
  logic [15:0] storedWord;

  // The stored word and the page-received flag live in the capture block.
  npa_word_capture u_capture (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .pageWordValid     (pageWordValid),
    .pageWord          (pageWord),
    .baseWord          (baseWord),
    .exchangeStart     (exchangeStart),
    .pageReceivedClear (pageReceivedClear),
    .storedWord        (storedWord),
    .pageReceived      (pageReceived),
    .toggleError       (toggleError)
  );

  // Two flip-flops on each pin, then a third on the clock for edge detection.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdcMeta_reg  <= 1'b0;
      mdcSync_reg  <= 1'b0;
      mdcLast_reg  <= 1'b0;
      mdioMeta_reg <= 1'b1;
      mdioSync_reg <= 1'b1;
    end else begin
      mdcMeta_reg  <= mdc;
      mdcSync_reg  <= mdcMeta_reg;
      mdcLast_reg  <= mdcSync_reg;
      mdioMeta_reg <= mdioIn;
      mdioSync_reg <= mdioMeta_reg;
    end
  end

  // Both pins share the same delay, so data stays aligned with its clock edge.
  assign mdcRise = mdcSync_reg & ~mdcLast_reg;
  assign bitIn   = mdioSync_reg;
  assign fieldIn = {field_reg[3:0], bitIn};

  // Frame decoder: one step per rising edge of the management clock.
  always_comb begin
    state_next  = state_reg;
    preCnt_next = preCnt_reg;
    bitCnt_next = bitCnt_reg;
    field_next  = field_reg;
    isRead_next = isRead_reg;
    match_next  = match_reg;
    shift_next  = shift_reg;
    out_next    = out_reg;
    oe_next     = oe_reg;
    if (mdcRise) begin
      case (state_reg)
        ST_PREAMBLE: begin
          oe_next  = 1'b0;
          out_next = 1'b0;
          if (bitIn) begin
            if (preCnt_reg != PREAMBLE_LEN) begin
              preCnt_next = preCnt_reg + 6'h01;
            end
          end else if (preCnt_reg == PREAMBLE_LEN) begin
            state_next = ST_START;
          end else begin
            preCnt_next = 6'h00;
          end
        end
        ST_START: begin
          preCnt_next = 6'h00;
          bitCnt_next = 5'h00;
          field_next  = 5'h00;
          state_next  = bitIn ? ST_OPCODE : ST_PREAMBLE;
        end
        ST_OPCODE: begin
          field_next  = fieldIn;
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == OP_BITS_LAST) begin
            bitCnt_next = 5'h00;
            isRead_next = (fieldIn[1:0] == OP_READ);
            if ((fieldIn[1:0] == OP_READ) || (fieldIn[1:0] == OP_WRITE)) begin
              state_next = ST_PHY;
            end else begin
              state_next = ST_PREAMBLE;
            end
          end
        end
        ST_PHY: begin
          field_next  = fieldIn;
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == ADDR_BITS_LAST) begin
            bitCnt_next = 5'h00;
            match_next  = (fieldIn == phyAddr);
            state_next  = ST_REG;
          end
        end
        ST_REG: begin
          field_next  = fieldIn;
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == ADDR_BITS_LAST) begin
            bitCnt_next = 5'h00;
            state_next  = ST_TURN;
            // The word is copied once here, so the read is one consistent page.
            if (fieldIn == ADDR_NEXT_PAGE) begin
              shift_next = storedWord;
            end else begin
              shift_next = 16'h0000;
            end
          end
        end
        ST_TURN: begin
          bitCnt_next = bitCnt_reg + 5'h01;
          if (bitCnt_reg == 5'h00) begin
            // The second turnaround bit is driven low by the device on reads addressed to its phyAddr.
            oe_next  = isRead_reg & match_reg;
            out_next = 1'b0;
          end
          if (bitCnt_reg == TA_BITS_LAST) begin
            bitCnt_next = 5'h00;
            state_next  = ST_DATA;
            out_next    = shift_reg[DATA_W-1];
            shift_next  = {shift_reg[DATA_W-2:0], 1'b0};
          end
        end
        ST_DATA: begin
          bitCnt_next = bitCnt_reg + 5'h01;
          out_next    = shift_reg[DATA_W-1];
          shift_next  = {shift_reg[DATA_W-2:0], 1'b0};
          // Writes land here too; the register is read-only so their data is dropped.
          if (bitCnt_reg == DATA_BITS_LAST) begin
            bitCnt_next = 5'h00;
            oe_next     = 1'b0;
            out_next    = 1'b0;
            state_next  = ST_PREAMBLE;
          end
        end
        default: begin
          state_next = ST_PREAMBLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // Frame decoder registers; the pin drivers are flip-flops for clean edges.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_PREAMBLE;
      preCnt_reg <= 6'h00;
      bitCnt_reg <= 5'h00;
      field_reg  <= 5'h00;
      isRead_reg <= 1'b0;
      match_reg  <= 1'b0;
      shift_reg  <= 16'h0000;
      out_reg    <= 1'b0;
      oe_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      preCnt_reg <= preCnt_next;
      bitCnt_reg <= bitCnt_next;
      field_reg  <= field_next;
      isRead_reg <= isRead_next;
      match_reg  <= match_next;
      shift_reg  <= shift_next;
      out_reg    <= out_next;
      oe_reg     <= oe_next;
    end
  end

  assign mdioOut     = out_reg;
  assign mdioOe      = oe_reg;
  assign partnerWord = storedWord;

endmodule

// file: bench/npa_properties.sv
`timescale 1ns/1ps
module npa_properties (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        pageWordValid,
  input  wire logic [15:0] pageWord,
  input  wire logic [15:0] baseWord,
  input  wire logic        exchangeStart,
  input  wire logic        pageReceivedClear,
  input  wire logic [15:0] partnerWord,
  input  wire logic        pageReceived,
  input  wire logic        toggleError
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Steps that most checks start from; a clear that shares a cycle with a page loses.
  sequence sCap; pageWordValid; endsequence
  sequence sClr; pageReceivedClear && !pageWordValid; endsequence
  sequence sFirst; exchangeStart && !pageWordValid ##1 pageWordValid; endsequence
  sequence sSame; pageWordValid ##1 pageWordValid && pageWord[11] == $past(pageWord[11]);
  endsequence
  chk_whole_word: assert property (sCap |=> partnerWord == ($past(pageWord) & 16'hbfff))
    else $error("stored word differs from page");
  chk_reserved_low: assert property (partnerWord[14] == 1'b0)
    else $error("reserved bit set");
  chk_more_pages: assert property (sCap |=> partnerWord[15] == $past(pageWord[15]))
    else $error("more pages flag wrong");
  chk_format_ack: assert property (sCap |=> partnerWord[13:12] == $past(pageWord[13:12]))
    else $error("format or acknowledge wrong");
  chk_code_field: assert property (sCap |=> partnerWord[10:0] == $past(pageWord[10:0]))
    else $error("code field wrong");
  chk_word_holds: assert property (!pageWordValid |=> $stable(partnerWord))
    else $error("word changed without page");
  chk_flag_set: assert property (sCap |=> pageReceived)
    else $error("page flag not set");
  chk_flag_clear: assert property (sClr |=> !pageReceived)
    else $error("page flag not cleared");
  chk_first_toggle: assert property (sFirst |=>
    toggleError == ($past(pageWord[11]) == $past(baseWord[11], 2)))
    else $error("first toggle judged wrongly");
  chk_toggle_repeat: assert property (sSame |=> toggleError)
    else $error("repeated toggle not flagged");
endmodule
bind next_page_partner_ability_reg npa_properties u_props (.clk_sys, .rst, .pageWordValid,
  .pageWord, .baseWord, .exchangeStart, .pageReceivedClear, .partnerWord, .pageReceived,
  .toggleError);

// file: bench/sta_model.sv
`timescale 1ns/1ps
module sta_model (
  input  wire logic clk_sys,
  input  wire logic mdioLine,
  output logic      mdc,
  output logic      staDrv,
  output logic      staEn
);
  // The management clock stands low between frames.
  initial begin
    mdc = 1'b0;
    staDrv = 1'b1;
    staEn = 1'b0;
  end
  // One bit: data changes while mdc is low, the line is sampled at the rise.
  task automatic bitx(input logic d, input logic en, output logic s);
    @(negedge clk_sys);
    staEn = en;
    staDrv = d;
    repeat (5) @(negedge clk_sys);
    mdc = 1'b1;
    s = mdioLine;
    repeat (5) @(negedge clk_sys);
    mdc = 1'b0;
  endtask
  // Full frame with preamble; the device lets go at the last data rise, then one idle rise follows.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic        s;
    logic        wr;
    hdr = {32'hffffffff, 2'h1, op, phy, rg};
    wr = (op == 2'h1);
    for (int i = 45; i >= 0; i--) bitx(hdr[i], 1'b1, s);
    bitx(1'b1, wr, s);
    bitx(1'b0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bitx(wd[i] & (i != 14), wr, s);
      rd[i] = s;
    end
    bitx(1'b1, 1'b0, s);
  endtask
endmodule

// file: bench/next_page_partner_ability_reg_bench.sv
`timescale 1ns/1ps
module next_page_partner_ability_reg_bench;
  import npa_pkg::*;
  logic        clk_sys = 0, rst = 1, mdc, mdioIn, mdioOut, mdioOe, staDrv, staEn;
  logic        pageWordValid = 0, exchangeStart = 0, pageReceivedClear = 0, vldD = 0;
  logic        pageReceived, toggleError, expTog = 0, errS = 0;
  logic [15:0] pageWord = 0, baseWord = 0, partnerWord, lfsr = 16'hb9e6, rd, w;
  logic [4:0]  phyAddr = 5'h06;
  logic [17:0] expQ[$];
  int          mismatches = 0, nChecks = 0;
  always #2 clk_sys = ~clk_sys;
  // The line has a pull-up, so a released line reads one.
  assign mdioIn = mdioOe ? mdioOut : (staEn ? staDrv : 1'b1);
  next_page_partner_ability_reg u_dut (.clk_sys, .rst, .mdc, .mdioIn, .mdioOut, .mdioOe,
    .phyAddr, .pageWordValid, .pageWord, .baseWord, .exchangeStart, .pageReceivedClear,
    .partnerWord, .pageReceived, .toggleError);
  sta_model u_sta (.clk_sys, .mdioLine(mdioIn), .mdc, .staDrv, .staEn);
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [17:0] e, input logic [17:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t expected %h got %h", $time, e, g);
    end
  endtask
  // Register reads are a result of their own, compared apart from the page results.
  task automatic chkRd(input logic [15:0] e, input logic [15:0] g);
    nChecks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t read expected %h got %h", $time, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Sends one page and notes the flags and word it should leave behind.
  task automatic page(input logic [15:0] v, input logic clr);
    @(negedge clk_sys);
    pageWordValid = 1;
    exchangeStart = 0;
    pageWord = v;
    pageReceivedClear = clr;
    errS = errS | (v[11] !== expTog);
    expTog = ~v[11];
    expQ.push_back({errS, 1'b1, v & 16'hbfff});
  endtask
  task automatic start(input logic [15:0] b);
    @(negedge clk_sys);
    pageWordValid = 0;
    exchangeStart = 1;
    baseWord = b;
    expTog = ~b[11];
    errS = 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys) begin
      pageWordValid = 0;
      exchangeStart = 0;
      pageReceivedClear = 0;
    end
  endtask
  task automatic rdReg(input logic [4:0] p, input logic [4:0] r, input logic [15:0] e);
    u_sta.frame(2'h2, p, r, 16'h0000, rd);
    chkRd(e, rd);
  endtask
  // The watcher takes the oldest note once a page's result has landed.
  always @(posedge clk_sys) vldD <= pageWordValid;
  always @(negedge clk_sys) begin
    if (vldD) chk(expQ.pop_front(), {toggleError, pageReceived, partnerWord});
  end
  // A hang is cut short and counted rather than left to run.
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) rst = 0;
    idle(4);
    chk(18'h00000, {toggleError, pageReceived, partnerWord});
    rdReg(phyAddr, 5'h08, 16'h0000);
    start(lfsr);
    for (int i = 0; i < 8; i++) begin
      lfsr = nextRand(lfsr);
      w = lfsr;
      {w[15], w[13], w[12]} = i[2:0];
      w[14] = ~i[0];
      w[11] = expTog;
      page(w, 1'b0);
    end
    page(w, 1'b0);
    idle(2);
    rdReg(phyAddr, 5'h08, w & 16'hbfff);
    @(negedge clk_sys) pageReceivedClear = 1;
    @(negedge clk_sys) pageReceivedClear = 0;
    chk({errS, 1'b0, w & 16'hbfff}, {toggleError, pageReceived, partnerWord});
    start(16'h0800);
    w[11] = 1'b1;
    page(w, 1'b1);
    idle(2);
    u_sta.frame(2'h1, phyAddr, 5'h08, 16'hffff, rd);
    rdReg(phyAddr, 5'h08, w & 16'hbfff);
    rdReg(phyAddr, 5'h09, 16'h0000);
    rdReg(phyAddr ^ 5'h01, 5'h08, 16'hffff);
    // An unknown opcode aborts the frame, so the line stays at its pull-up level.
    u_sta.frame(2'h3, phyAddr, 5'h08, 16'h0000, rd);
    chkRd(16'hffff, rd);
    // A reset in mid-run must bring a loaded register back to zero.
    @(negedge clk_sys) rst = 1;
    idle(2);
    chk(18'h00000, {toggleError, pageReceived, partnerWord});
    rst = 0;
    idle(4);
    rdReg(phyAddr, 5'h08, 16'h0000);
    idle(2);
    end_of_test();
  end
endmodule
